// >>> hw/dro_cfg.svh
// register selects, field positions and reset values for debug ownership
`ifndef DRO_CFG_SVH
`define DRO_CFG_SVH

// ----------------------------------------------------------------
// register selects (word index on both access ports)
// ----------------------------------------------------------------
`define DRO_NWORDS 20
`define DRO_SEL_W 5
`define DRO_SEL_CTRL0 5'h00
`define DRO_SEL_CTRL1 5'h01
`define DRO_SEL_CTRL5 5'h02
`define DRO_SEL_CTRL6 5'h03
`define DRO_SEL_COUNT 5'h04
`define DRO_SEL_EVSEL 5'h05
`define DRO_SEL_ACQ 5'h06
`define DRO_SEL_IADDR 5'h07
`define DRO_SEL_DADDR1 5'h0F
`define DRO_SEL_DADDR2 5'h10
`define DRO_SEL_DVAL1 5'h11
`define DRO_SEL_DVAL2 5'h12
`define DRO_SEL_SPARE 5'h13
`define DRO_SEL_ALLOC 5'h14

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define DRO_B_EDM 0
`define DRO_B_IDM 1
`define DRO_B_RST 2
`define DRO_B_DATA_COMPARE_ONE 12
`define DRO_B_DATA_COMPARE_TWO 14
`define DRO_B_COUNTER_A_EVENT 23
`define DRO_B_COUNTER_B_EVENT 24
`define DRO_B_BKPT 27
`define DRO_B_DQM 28
`define DRO_B_PAIR_AB 7
`define DRO_B_PAIR_CD 23
`define DRO_ALLOC_IMPL 32'h9FFF_5FFE
`define DRO_CTRL0_SW 32'h87FF_5FFE
`define DRO_TAG_FLD 32'h0000_00FF

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define DRO_ALLOC_RST 32'h0000_0000
`define DRO_WORD_RST 32'h0000_0000

`endif

// >>> hw/dro_pkg.sv
// types shared by the debug resource ownership block
`include "dro_cfg.svh"

package dro_pkg;

  typedef logic [`DRO_NWORDS-1:0][31:0] dro_words_t;
  typedef logic [`DRO_SEL_W-1:0] dro_sel_t;

  typedef struct packed {
    logic wr;
    logic rd;
    dro_sel_t sel;
    logic [31:0] wdata;
  } dro_req_t;

  typedef struct packed {
    logic [31:0] alloc;
    dro_words_t regs;
    logic [31:0] sw_rdata;
    logic sw_rvalid;
    logic [31:0] dbg_rdata;
    logic dbg_rvalid;
    logic [31:0] hw_event;
    logic [31:0] sw_event;
    logic bkpt_dbg;
    logic bkpt_ill;
  } dro_state_t;

endpackage : dro_pkg

// >>> hw/dro_ownership_map.sv
// software ownership masks derived from the allocation word
`include "dro_cfg.svh"

module dro_ownership_map import dro_pkg::*; (
  // allocation inputs
  input wire logic [31:0] i_alloc,
  input wire logic i_ext_on,
  // ownership outputs
  output dro_words_t o_sw_mask,
  output logic [31:0] o_sw_events
);

  logic [31:0] a;
  logic [7:0] ic;

  always_comb begin
    a = i_alloc & `DRO_ALLOC_IMPL;
    ic = {a[20:17], a[11:8]};
    o_sw_mask = '0;
    o_sw_events = 32'h0000_0000;
    if (!i_ext_on) begin
      o_sw_mask = '1;
      o_sw_events = 32'hFFFF_FFFF;
    end else if (a[`DRO_B_IDM]) begin
      o_sw_events = a;
      o_sw_mask[`DRO_SEL_CTRL0] = a & `DRO_CTRL0_SW;
      for (int k = 0; k < 4; k++) begin
        o_sw_mask[`DRO_SEL_CTRL1][8*k +: 6] = {6{ic[k]}};
        o_sw_mask[`DRO_SEL_CTRL5][8*k +: 6] = {6{ic[k+4]}};
      end
      o_sw_mask[`DRO_SEL_CTRL1][`DRO_B_PAIR_AB] = ic[0] & ic[1];
      o_sw_mask[`DRO_SEL_CTRL1][`DRO_B_PAIR_CD] = ic[2] & ic[3];
      o_sw_mask[`DRO_SEL_CTRL5][`DRO_B_PAIR_AB] = ic[4] & ic[5];
      o_sw_mask[`DRO_SEL_CTRL5][`DRO_B_PAIR_CD] = ic[6] & ic[7];
      for (int k = 0; k < 8; k++) begin
        o_sw_mask[`DRO_SEL_CTRL6][4*k +: 4] = {4{ic[k]}};
        o_sw_mask[`DRO_SEL_IADDR + k] = {32{ic[k]}};
      end
      o_sw_mask[`DRO_SEL_COUNT] = {{16{a[`DRO_B_COUNTER_B_EVENT]}},
                                   {16{a[`DRO_B_COUNTER_A_EVENT]}}};
      o_sw_mask[`DRO_SEL_EVSEL] = {32{a[`DRO_B_DQM]}};
      o_sw_mask[`DRO_SEL_ACQ] = {32{a[`DRO_B_DQM]}};
      o_sw_mask[`DRO_SEL_DADDR1] = {32{a[`DRO_B_DATA_COMPARE_ONE]}};
      o_sw_mask[`DRO_SEL_DVAL1] = {32{a[`DRO_B_DATA_COMPARE_ONE]}};
      o_sw_mask[`DRO_SEL_DADDR2] = {32{a[`DRO_B_DATA_COMPARE_TWO]}};
      o_sw_mask[`DRO_SEL_DVAL2] = {32{a[`DRO_B_DATA_COMPARE_TWO]}};
    end
    o_sw_mask[`DRO_SEL_CTRL0][`DRO_B_EDM] = 1'b0;
    o_sw_mask[`DRO_SEL_EVSEL] = o_sw_mask[`DRO_SEL_EVSEL] & `DRO_TAG_FLD;
  end

endmodule // dro_ownership_map

// >>> hw/dro_reg_gate.sv
// next value of one debug register under masked writes and reset
`include "dro_cfg.svh"

module dro_reg_gate (
  // current word
  input wire logic [31:0] i_old,
  // software move
  input wire logic i_sw_we,
  input wire logic [31:0] i_sw_data,
  input wire logic [31:0] i_sw_mask,
  // debugger access
  input wire logic i_dbg_we,
  input wire logic [31:0] i_dbg_data,
  // processor reset
  input wire logic i_rst_en,
  input wire logic [31:0] i_rst_mask,
  // next word
  output logic [31:0] o_next
);

  always_comb begin
    o_next = i_old;
    if (i_rst_en) begin
      o_next = o_next & ~i_rst_mask;
    end
    if (i_sw_we) begin
      o_next = (o_next & ~i_sw_mask) | (i_sw_data & i_sw_mask);
    end
    if (i_dbg_we) begin
      o_next = i_dbg_data;
    end
  end

endmodule // dro_reg_gate

// >>> hw/dro_top.sv
// debug resource ownership: allocation word, gated debug registers
//
// Summary of operation
// - ownership idm bit clear ignores software moves
// - idm bit clear: nothing shared with software
// - idm bit set: software owns idm control
// - bit 2 gives reset field to software
// - bit 3 gives unconditional event to software
// - event enable bits follow their allocation bits
// - compare bits 8-11, 17-20 gate compare fields
// - compares 1-4: address, enable, ctrl1, ctrl6
// - compares 5-8: address, enable, ctrl5, ctrl6
// - bits 12, 14 gate data compares
// - data compare one: address, value, fields
// - bits 23, 24 gate counter fields
// - breakpoint: hardware enters debug, software illegal
// - bit 28 gates tag and message registers
// - bit 31 gates freeze timer field
// - external mode off: all accessible and reset except edm bit, evsel bits 31:8
// - allocation ignored while external mode off
// - only debugger writes allocation; software reads
// - events routed to owner's status path
`include "dro_cfg.svh"

module dro_top import dro_pkg::*; (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // other resets
  input wire logic i_proc_rst,
  input wire logic i_test_reset,
  // debugger access
  input wire dro_req_t i_dbg,
  output logic [31:0] o_dbg_rdata,
  output logic o_dbg_rvalid,
  // software moves
  input wire dro_req_t i_sw,
  output logic [31:0] o_sw_rdata,
  output logic o_sw_rvalid,
  // debug events
  input wire logic [31:0] i_event,
  input wire logic i_bkpt_exec,
  output logic [31:0] o_hw_event,
  output logic [31:0] o_sw_event,
  output logic o_bkpt_enter_debug,
  output logic o_bkpt_illegal,
  // state view
  output logic [31:0] o_alloc,
  output logic [31:0] o_ctrl_zero
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic sel_hit(input dro_sel_t s, input int unsigned i);
    return s == dro_sel_t'(i);
  endfunction

  function automatic logic sel_word(input dro_sel_t s);
    return s < dro_sel_t'(`DRO_NWORDS);
  endfunction

  // ----------------------------------------------------------------
  // state and ownership
  // ----------------------------------------------------------------
  dro_state_t st_r;
  dro_state_t st_nxt;
  dro_words_t sw_mask;
  dro_words_t rst_mask;
  dro_words_t regs_nxt;
  logic [31:0] sw_events;
  logic ext_on;
  logic idm_on;
  logic bkpt_hw;

  assign ext_on = st_r.regs[`DRO_SEL_CTRL0][`DRO_B_EDM];
  assign idm_on = st_r.regs[`DRO_SEL_CTRL0][`DRO_B_IDM];

  dro_ownership_map u_map (
    .i_alloc(st_r.alloc),
    .i_ext_on(ext_on),
    .o_sw_mask(sw_mask),
    .o_sw_events(sw_events)
  );

  always_comb begin
    rst_mask = sw_mask;
    rst_mask[`DRO_SEL_CTRL0][`DRO_B_RST] = 1'b1;
  end

  // ----------------------------------------------------------------
  // register update
  // ----------------------------------------------------------------
  for (genvar g = 0; g < `DRO_NWORDS; g++) begin : g_word
    dro_reg_gate u_gate (
      .i_old(st_r.regs[g]),
      .i_sw_we(i_sw.wr & sel_hit(i_sw.sel, g)),
      .i_sw_data(i_sw.wdata),
      .i_sw_mask(sw_mask[g]),
      .i_dbg_we(i_dbg.wr & sel_hit(i_dbg.sel, g)),
      .i_dbg_data(i_dbg.wdata),
      .i_rst_en(i_proc_rst),
      .i_rst_mask(rst_mask[g]),
      .o_next(regs_nxt[g])
    );
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.regs = regs_nxt;
    st_nxt.sw_rvalid = 1'b0;
    st_nxt.dbg_rvalid = 1'b0;
    bkpt_hw = ext_on & ~(st_r.alloc[`DRO_B_IDM] & st_r.alloc[`DRO_B_BKPT]);
    if (i_test_reset) begin
      st_nxt.alloc = `DRO_ALLOC_RST;
    end else if (i_dbg.wr && sel_hit(i_dbg.sel, `DRO_SEL_ALLOC)) begin
      st_nxt.alloc = i_dbg.wdata & `DRO_ALLOC_IMPL;
    end
    if (i_sw.rd) begin
      st_nxt.sw_rvalid = 1'b1;
      st_nxt.sw_rdata = 32'h0000_0000;
      if (sel_hit(i_sw.sel, `DRO_SEL_ALLOC)) begin
        st_nxt.sw_rdata = st_r.alloc;
      end else if (sel_word(i_sw.sel)) begin
        st_nxt.sw_rdata = st_r.regs[i_sw.sel] & sw_mask[i_sw.sel];
      end
    end
    if (i_dbg.rd) begin
      st_nxt.dbg_rvalid = 1'b1;
      st_nxt.dbg_rdata = 32'h0000_0000;
      if (sel_hit(i_dbg.sel, `DRO_SEL_ALLOC)) begin
        st_nxt.dbg_rdata = st_r.alloc;
      end else if (sel_word(i_dbg.sel)) begin
        st_nxt.dbg_rdata = st_r.regs[i_dbg.sel];
      end
    end
    st_nxt.hw_event = ext_on ? (i_event & ~sw_events) : 32'h0000_0000;
    st_nxt.sw_event = i_event & sw_events & {32{idm_on}};
    st_nxt.bkpt_dbg = i_bkpt_exec & bkpt_hw;
    st_nxt.bkpt_ill = i_bkpt_exec & ~bkpt_hw;
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r <= '0;
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_dbg_rdata = st_r.dbg_rdata;
  assign o_dbg_rvalid = st_r.dbg_rvalid;
  assign o_sw_rdata = st_r.sw_rdata;
  assign o_sw_rvalid = st_r.sw_rvalid;
  assign o_hw_event = st_r.hw_event;
  assign o_sw_event = st_r.sw_event;
  assign o_bkpt_enter_debug = st_r.bkpt_dbg;
  assign o_bkpt_illegal = st_r.bkpt_ill;
  assign o_alloc = st_r.alloc;
  assign o_ctrl_zero = st_r.regs[`DRO_SEL_CTRL0];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_sw_move_ignored: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_ce && i_sw.wr && ext_on && !st_r.alloc[`DRO_B_IDM] && !i_dbg.wr &&
    !i_proc_rst |=> $stable(st_r.regs))
    else $error("software move changed a register with idm unallocated");

  a_no_sharing: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    ext_on && !st_r.alloc[`DRO_B_IDM] |-> sw_mask == '0 && sw_events == '0)
    else $error("resource shared while idm unallocated");

  a_idm_sw_write: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_ce && i_sw.wr && sel_hit(i_sw.sel, `DRO_SEL_CTRL0) && ext_on &&
    st_r.alloc[`DRO_B_IDM] && !i_dbg.wr
    |=> o_ctrl_zero[`DRO_B_IDM] == $past(i_sw.wdata[`DRO_B_IDM]))
    else $error("software could not write the idm control bit");

  a_rst_field_hw: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_ce && i_sw.wr && sel_hit(i_sw.sel, `DRO_SEL_CTRL0) && ext_on &&
    !st_r.alloc[`DRO_B_RST] && !i_dbg.wr && !i_proc_rst
    |=> $stable(o_ctrl_zero[`DRO_B_RST]))
    else $error("software changed a hardware-owned reset field");

  a_event_to_hw: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_ce && i_event[3] && ext_on &&
    !(st_r.alloc[`DRO_B_IDM] && st_r.alloc[3])
    |=> o_hw_event[3] && !o_sw_event[3])
    else $error("hardware-owned event not routed to hardware status");

  a_bkpt_sw_owned: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_ce && i_bkpt_exec && ext_on && st_r.alloc[`DRO_B_IDM] &&
    st_r.alloc[`DRO_B_BKPT] |=> o_bkpt_illegal && !o_bkpt_enter_debug)
    else $error("software breakpoint did not raise illegal instruction");

  a_bkpt_hw_owned: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_ce && i_bkpt_exec && ext_on && !st_r.alloc[`DRO_B_BKPT]
    |=> o_bkpt_enter_debug && !o_bkpt_illegal)
    else $error("hardware breakpoint did not enter debug mode");

  a_proc_rst_all: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_ce && i_proc_rst && !ext_on && !i_sw.wr && !i_dbg.wr
    |=> st_r.regs[`DRO_SEL_ACQ] == '0 &&
        st_r.regs[`DRO_SEL_COUNT] == '0 &&
        o_ctrl_zero[31:1] == '0)
    else $error("processor reset left a register set with external off");

  a_pair_mode: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    ext_on && st_r.alloc[`DRO_B_IDM] |->
    sw_mask[`DRO_SEL_CTRL1][`DRO_B_PAIR_AB] ==
    (st_r.alloc[8] && st_r.alloc[9]))
    else $error("pair mode field ownership wrong");

  a_reserved_zero: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (o_alloc & ~`DRO_ALLOC_IMPL) == '0)
    else $error("reserved allocation bit set");

  a_alloc_sw_ro: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_ce && i_sw.wr && !i_dbg.wr && !i_test_reset |=> $stable(o_alloc))
    else $error("software move changed the allocation word");

  a_ext_off_ignored: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    !ext_on |-> sw_mask[`DRO_SEL_ACQ] == '1 && sw_events == '1)
    else $error("allocation took effect with external mode off");

  a_dac_gate: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_ce && i_sw.wr && sel_hit(i_sw.sel, `DRO_SEL_DADDR2) && ext_on &&
    !st_r.alloc[`DRO_B_DATA_COMPARE_TWO] && !i_dbg.wr && !i_proc_rst
    |=> $stable(st_r.regs[`DRO_SEL_DADDR2]))
    else $error("software wrote a hardware-owned data compare");

  a_read_latency: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_ce && i_sw.rd && sel_hit(i_sw.sel, `DRO_SEL_ALLOC)
    |=> o_sw_rvalid && o_sw_rdata == $past(o_alloc))
    else $error("allocation word read back wrong");

  a_ude_sw_route: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_ce && i_event[3] && ext_on && idm_on && st_r.alloc[`DRO_B_IDM] &&
    st_r.alloc[3] |=> o_sw_event[3] && !o_hw_event[3])
    else $error("software-owned unconditional event misrouted");

  a_enable_gate: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_ce && i_sw.wr && sel_hit(i_sw.sel, `DRO_SEL_CTRL0) && ext_on &&
    !st_r.alloc[4] && !i_dbg.wr && !i_proc_rst
    |=> $stable(o_ctrl_zero[4]))
    else $error("software changed a hardware-owned event enable");

  a_iac_addr_gate: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_ce && i_sw.wr && sel_hit(i_sw.sel, `DRO_SEL_IADDR) && ext_on &&
    !st_r.alloc[8] && !i_dbg.wr && !i_proc_rst
    |=> $stable(st_r.regs[`DRO_SEL_IADDR]))
    else $error("software wrote a hardware-owned instruction compare");

  a_instr_compare_one_fields: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    ext_on && st_r.alloc[`DRO_B_IDM] |->
    sw_mask[`DRO_SEL_CTRL1][5:0] == {6{st_r.alloc[8]}} &&
    sw_mask[`DRO_SEL_CTRL6][3:0] == {4{st_r.alloc[8]}})
    else $error("compare one field ownership wrong");

  a_instr_compare_five_fields: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    ext_on && st_r.alloc[`DRO_B_IDM] |->
    sw_mask[`DRO_SEL_CTRL5][5:0] == {6{st_r.alloc[17]}} &&
    sw_mask[`DRO_SEL_CTRL6][19:16] == {4{st_r.alloc[17]}})
    else $error("compare five field ownership wrong");

  a_data_compare_one_fields: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    ext_on && st_r.alloc[`DRO_B_IDM] |->
    sw_mask[`DRO_SEL_DADDR1] == {32{st_r.alloc[`DRO_B_DATA_COMPARE_ONE]}} &&
    sw_mask[`DRO_SEL_DVAL1] == {32{st_r.alloc[`DRO_B_DATA_COMPARE_ONE]}})
    else $error("data compare one ownership wrong");

  a_counter_gate: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    ext_on && st_r.alloc[`DRO_B_IDM] |->
    sw_mask[`DRO_SEL_COUNT][15:0] == {16{st_r.alloc[`DRO_B_COUNTER_A_EVENT]}} &&
    sw_mask[`DRO_SEL_COUNT][31:16] == {16{st_r.alloc[`DRO_B_COUNTER_B_EVENT]}})
    else $error("counter ownership wrong");

  a_acq_gate: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_ce && i_sw.wr && sel_hit(i_sw.sel, `DRO_SEL_ACQ) && ext_on &&
    !st_r.alloc[`DRO_B_DQM] && !i_dbg.wr && !i_proc_rst
    |=> $stable(st_r.regs[`DRO_SEL_ACQ]))
    else $error("software wrote a hardware-owned message register");

  a_freeze_gate: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_ce && i_sw.wr && sel_hit(i_sw.sel, `DRO_SEL_CTRL0) && ext_on &&
    !st_r.alloc[31] && !i_dbg.wr && !i_proc_rst
    |=> $stable(o_ctrl_zero[31]))
    else $error("software changed a hardware-owned freeze field");

  a_masked_reset: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_ce && i_proc_rst && ext_on && !st_r.alloc[`DRO_B_IDM] && !i_sw.wr &&
    !i_dbg.wr |=> $stable(st_r.regs[`DRO_SEL_ACQ]) &&
    !o_ctrl_zero[`DRO_B_RST])
    else $error("processor reset cleared a hardware-owned word");

  a_ext_off_route: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_ce && !ext_on && idm_on && i_event[4]
    |=> o_sw_event[4] && !o_hw_event[4])
    else $error("event not given to software with external mode off");

  a_hw_quiet_off: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_ce && !ext_on |=> o_hw_event == '0)
    else $error("hardware event raised with external mode off");

  a_sw_read_mask: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_ce && i_sw.rd && sel_hit(i_sw.sel, `DRO_SEL_CTRL0) && ext_on &&
    !st_r.alloc[`DRO_B_IDM] |=> o_sw_rvalid && o_sw_rdata == '0)
    else $error("software read a hardware-owned control word");

  a_idm_owned: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    ext_on && st_r.alloc[`DRO_B_IDM] |->
    sw_mask[`DRO_SEL_CTRL0][`DRO_B_IDM] &&
    !sw_mask[`DRO_SEL_CTRL0][`DRO_B_EDM] &&
    sw_mask[`DRO_SEL_CTRL0][`DRO_B_RST] == st_r.alloc[`DRO_B_RST])
    else $error("control word ownership of mode bits wrong");

  a_ctrl0_reserved: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    ext_on |-> (sw_mask[`DRO_SEL_CTRL0] & ~`DRO_CTRL0_SW) == '0)
    else $error("unallocatable control bit given to software");

  a_dbg_read: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_ce && i_dbg.rd && sel_hit(i_dbg.sel, `DRO_SEL_ALLOC)
    |=> o_dbg_rvalid && o_dbg_rdata == $past(o_alloc))
    else $error("debugger read of allocation word wrong");

  a_rvalid_pulse: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_ce && !i_sw.rd |=> !o_sw_rvalid)
    else $error("software read valid without a read");

endmodule // dro_top

// >>> hw/unused_placeholder_none.sv
// intentionally empty compilation unit

// >>> dv/dro_dbg_model.sv
// external debugger model on the debug access port
module dro_dbg_model import dro_pkg::*; (
  // clock
  input wire logic i_core_clk,
  // debug access
  output dro_req_t o_req,
  input wire logic [31:0] i_rdata,
  input wire logic i_rvalid
);
  timeunit 1ns;
  timeprecision 1ns;
  // --------------------------------------------------------------
  // full access to every word, allocation word included
  // --------------------------------------------------------------
  initial o_req = '0;
  task automatic wr(input dro_sel_t s, input logic [31:0] d);
    @(negedge i_core_clk);
    o_req = '{wr: 1'b1, rd: 1'b0, sel: s, wdata: d};
    @(negedge i_core_clk);
    o_req = '0;
  endtask
  task automatic rd(input dro_sel_t s, output logic [31:0] d);
    @(negedge i_core_clk);
    o_req = '{wr: 1'b0, rd: 1'b1, sel: s, wdata: 32'h0000_0000};
    @(negedge i_core_clk);
    o_req = '0;
    d = i_rvalid ? i_rdata : 32'hDEAD_BEEF;
  endtask
endmodule // dro_dbg_model

// >>> dv/dro_top_bench.sv
// self-checking bench for the debug resource ownership block
`include "dro_cfg.svh"
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
  bad_count++; $display("Error %s exp %h got %h", nm, ex, got); end end
module dro_top_bench import dro_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_proc_rst = 1'b0;
  logic i_test_reset = 1'b0;
  logic i_bkpt_exec = 1'b0;
  logic i_ce = 1'b1;
  logic [31:0] i_event = '0;
  dro_req_t i_sw = '0;
  dro_req_t dbg_req;
  logic [31:0] dbg_rdata, sw_rdata, hw_ev, sw_ev, alloc, ctrl0, v;
  logic dbg_rvalid, sw_rvalid, bk_dbg, bk_ill;
  int bad_count = 0;
  int compares = 0;
  always #10 i_core_clk = ~i_core_clk;
  dro_top u_dro_top (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_ce(i_ce),
    .i_proc_rst(i_proc_rst), .i_test_reset(i_test_reset), .i_dbg(dbg_req),
    .o_dbg_rdata(dbg_rdata), .o_dbg_rvalid(dbg_rvalid), .i_sw(i_sw),
    .o_sw_rdata(sw_rdata), .o_sw_rvalid(sw_rvalid), .i_event(i_event),
    .i_bkpt_exec(i_bkpt_exec), .o_hw_event(hw_ev), .o_sw_event(sw_ev),
    .o_bkpt_enter_debug(bk_dbg), .o_bkpt_illegal(bk_ill),
    .o_alloc(alloc), .o_ctrl_zero(ctrl0));
  dro_dbg_model u_dro_dbg_model (.i_core_clk(i_core_clk), .o_req(dbg_req),
    .i_rdata(dbg_rdata), .i_rvalid(dbg_rvalid));
  // --------------------------------------------------------------
  // access helpers
  // --------------------------------------------------------------
  task automatic dw(input dro_sel_t s, input logic [31:0] d);
    u_dro_dbg_model.wr(s, d);
  endtask
  task automatic sw_wr(input dro_sel_t s, input logic [31:0] d);
    @(negedge i_core_clk);
    i_sw = '{wr: 1'b1, rd: 1'b0, sel: s, wdata: d};
    @(negedge i_core_clk);
    i_sw = '0;
  endtask
  task automatic sw_rd(input dro_sel_t s, output logic [31:0] d);
    @(negedge i_core_clk);
    i_sw = '{wr: 1'b0, rd: 1'b1, sel: s, wdata: 32'h0000_0000};
    @(negedge i_core_clk);
    i_sw = '0;
    d = sw_rvalid ? sw_rdata : 32'hDEAD_BEEF;
  endtask
  task automatic pulse_rst(input logic pr);
    @(negedge i_core_clk);
    if (pr) i_proc_rst = 1'b1;
    else i_test_reset = 1'b1;
    @(negedge i_core_clk);
    i_proc_rst = 1'b0;
    i_test_reset = 1'b0;
  endtask
  task automatic bk(input logic ed, input logic il);
    @(negedge i_core_clk);
    i_bkpt_exec = 1'b1;
    @(negedge i_core_clk);
    i_bkpt_exec = 1'b0;
    `CHK("bkpt_debug", ed, bk_dbg)
    `CHK("bkpt_illegal", il, bk_ill)
  endtask
  // software fills a word, the debugger reads it back
  task automatic own(input logic [31:0] a, input dro_sel_t s,
                     input logic [31:0] m, input logic [31:0] ex);
    dw(`DRO_SEL_ALLOC, a);
    sw_wr(s, 32'hFFFF_FFFF);
    u_dro_dbg_model.rd(s, v);
    `CHK("owned_word", ex, v & m)
  endtask
  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_alloc_reg;
    `CHK("alloc_reset", 32'h0000_0000, alloc)
    dw(`DRO_SEL_ALLOC, 32'hFFFF_FFFF);
    u_dro_dbg_model.rd(`DRO_SEL_ALLOC, v);
    `CHK("alloc_reserved", 32'h9FFF_5FFE, v)
    sw_rd(`DRO_SEL_ALLOC, v);
    `CHK("alloc_sw_read", 32'h9FFF_5FFE, v)
    sw_wr(`DRO_SEL_ALLOC, 32'h0000_0000);
    `CHK("alloc_sw_write", 32'h9FFF_5FFE, alloc)
    pulse_rst(1'b1);
    `CHK("alloc_proc_rst", 32'h9FFF_5FFE, alloc)
    pulse_rst(1'b0);
    `CHK("alloc_test_rst", 32'h0000_0000, alloc)
  endtask
  task automatic t_ext_off;
    own(32'h0000_0000, `DRO_SEL_COUNT, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
    sw_wr(`DRO_SEL_CTRL0, 32'h87FF_5FFE);
    `CHK("ctrl0_ext_off", 32'h87FF_5FFE, ctrl0)
    pulse_rst(1'b1);
    `CHK("ctrl0_proc_rst", 32'h0000_0000, ctrl0)
    bk(1'b0, 1'b1);
  endtask
  task automatic t_idm_clear;
    dw(`DRO_SEL_CTRL0, 32'h0000_0001);
    own(32'h9FFF_5FFC, `DRO_SEL_COUNT, 32'hFFFF_FFFF, 32'h0);
    sw_wr(`DRO_SEL_CTRL0, 32'hFFFF_FFFF);
    `CHK("ctrl0_idm_clear", 32'h0000_0001, ctrl0)
    sw_rd(`DRO_SEL_CTRL0, v);
    `CHK("ctrl0_sw_read", 32'h0000_0000, v)
    bk(1'b1, 1'b0);
  endtask
  task automatic t_bits;
    logic [31:0] ex;
    for (int b = 1; b < 32; b++) begin
      if (b == 13 || b == 15 || b == 29 || b == 30) continue;
      ex = 32'h1 | ((32'h2 | (32'h1 << b)) & `DRO_CTRL0_SW);
      dw(`DRO_SEL_ALLOC, 32'h2 | (32'h1 << b));
      dw(`DRO_SEL_CTRL0, 32'h0000_0001);
      sw_wr(`DRO_SEL_CTRL0, 32'hFFFF_FFFF);
      `CHK("ctrl0_owned", ex, ctrl0)
      pulse_rst(1'b1);
      `CHK("ctrl0_masked_rst", 32'h0000_0001, ctrl0)
    end
  endtask
  task automatic t_fields;
    own(32'h0000_0102, `DRO_SEL_CTRL1, 32'hFFFF_FFFF, 32'h3F);
    own(32'h0000_0302, `DRO_SEL_CTRL1, 32'hFFFF_FFFF, 32'h3FBF);
    own(32'h0000_0102, `DRO_SEL_CTRL6, 32'hFFFF_FFFF, 32'hF);
    own(32'h0006_0002, `DRO_SEL_CTRL5, 32'hFFFF_FFFF, 32'h3FBF);
    own(32'h0000_1002, `DRO_SEL_DVAL1, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
    own(32'h0000_1002, `DRO_SEL_DADDR2, 32'hFFFF_FFFF, 32'h0);
    own(32'h0000_0002, `DRO_SEL_ACQ, 32'hFFFF_FFFF, 32'h0);
    own(32'h1000_0002, `DRO_SEL_ACQ, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
    own(32'h1000_0002, `DRO_SEL_EVSEL, `DRO_TAG_FLD, 32'hFF);
  endtask
  task automatic t_events;
    dw(`DRO_SEL_ALLOC, 32'h0800_0012);
    dw(`DRO_SEL_CTRL0, 32'h0000_0021);
    sw_wr(`DRO_SEL_CTRL0, 32'hFFFF_FFFF);
    sw_rd(`DRO_SEL_CTRL0, v);
    `CHK("ctrl0_sw_masked", 32'h0000_0012, v)
    @(negedge i_core_clk);
    i_event = 32'h0000_0030;
    @(negedge i_core_clk);
    i_event = '0;
    `CHK("sw_event", 32'h0000_0010, sw_ev)
    `CHK("hw_event", 32'h0000_0020, hw_ev)
    bk(1'b0, 1'b1);
    dw(`DRO_SEL_ALLOC, 32'h0000_0002);
    bk(1'b1, 1'b0);
  endtask
  // a low clock enable holds the allocation word
  task automatic t_ce;
    @(negedge i_core_clk);
    i_ce = 1'b0;
    dw(`DRO_SEL_ALLOC, 32'h0000_0012);
    `CHK("alloc_frozen", 32'h0000_0002, alloc)
    i_ce = 1'b1;
    dw(`DRO_SEL_ALLOC, 32'h0000_0012);
    `CHK("alloc_thawed", 32'h0000_0012, alloc)
  endtask
  // --------------------------------------------------------------
  // sequence, verdict and watchdog
  // --------------------------------------------------------------
  task automatic test_done;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge i_core_clk);
    i_rst = 1'b0;
    t_alloc_reg();
    t_ext_off();
    t_idm_clear();
    t_bits();
    t_fields();
    t_events();
    t_ce();
    test_done();
  end
  initial begin
    #(20 * 5000);
    bad_count++;
    test_done();
  end
endmodule // dro_top_bench
